// file: src/pbi_pkg.sv
/*
 * Constants of the page and burst bus interface: configuration fields,
 * burst length codes, state encodings and timing counts.
 * Assumes a 125 MHz core clock and configuration words held outside.
 */
// What this block does
// [RULE1] Low four address bits pick the page word.
// [RULE2] Upper address change restarts a full access.
// [RULE3] Writes have no page fast path.
// [RULE4] Refresh configuration bit seven enables page reads.
// [RULE5] Host holds clocks low in page reads.
// [RULE6] Host bounds the select low time.
// [RULE7] First edge with address-valid low takes address.
// [RULE8] Bursts are 4, 8, 16, 32 words or to row end; other length codes give continuous bursts that run on past row ends.
// [RULE9] Latency sets first word; writes use fixed latency.
// [RULE10] Refresh collision extends variable latency wait.
// [RULE11] Fixed latency includes refresh allowance.
// [RULE12] Host ignoring wait stops at row ends.
// [RULE13] Wait marks burst start and row end.
// [RULE14] One word per edge after wait.
// [RULE15] Stopped clock suspends a burst.
// [RULE16] Wait timing bit zero shifts wait early.
// [RULE17] Host keeps select low in wait cycles.
// [RULE18] Wait stays driven in asynchronous accesses.
// [RULE19] Asynchronous accesses work with clock low.
// [RULE20] Disabled lanes stay unchanged.
// [RULE21] Write data taken at first strobe rise.
// [RULE22] Both lanes off floats the data bus.
// [RULE23] Bus configuration bit fifteen picks asynchronous mode.
// [RULE24] Bus configuration bit ten sets wait polarity.
// [RULE25] Low lane is bits seven to zero.
// [RULE26] Select and access times are parameters.
package pbi_pkg;
    // ----------------------------------------
    // Configuration fields
    // ----------------------------------------
    localparam int BC_ASYNC_BIT = 15;
    localparam int BC_FIXED_LAT_BIT = 14;
    localparam int BC_LAT_HI = 13;
    localparam int BC_LAT_LO = 11;
    localparam int BC_WAIT_POL_BIT = 10;
    localparam int BC_WAIT_CFG_BIT = 8;
    localparam int BC_NO_WRAP_BIT = 3;
    localparam int BC_LEN_HI = 2;
    localparam int BC_LEN_LO = 0;
    localparam int RC_PAGE_BIT = 7;
    localparam int PAGE_BITS = 4;
    localparam int DATA_W = 16;

    // ----------------------------------------
    // Burst length codes
    // ----------------------------------------
    localparam logic [2:0] LEN_4 = 3'h1;
    localparam logic [2:0] LEN_8 = 3'h2;
    localparam logic [2:0] LEN_16 = 3'h3;
    localparam logic [2:0] LEN_32 = 3'h4;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int RANDOM_ACCESS_TIME_NS = 70;
    localparam int PAGE_ACCESS_TIME_NS = 20;
    localparam int MAX_SELECT_LOW_TIME_NS = 4000;
    localparam int REFRESH_TIME_NS = 60;
    localparam int ACC_CYC = (RANDOM_ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PAGE_CYC = (PAGE_ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SEL_CYC = (MAX_SELECT_LOW_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int REF_CYC = (REFRESH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int REF_ALLOW_CLKS = 3;

    typedef enum logic [1:0] {
        PBI_IDLE = 2'b00,
        PBI_LAT = 2'b01,
        PBI_XFER = 2'b10,
        PBI_ROW = 2'b11
    } pbi_state_e;
endpackage

// file: src/pbi_mem_if.sv
/*
 * Carrier between the bus controller and its word array.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface pbi_mem_if #(parameter int ADDR_W = 10);
    logic wr_en;
    logic [1:0] byte_en;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport ctrl (output wr_en, byte_en, addr, wdata, input rdata);
    modport mem (input wr_en, byte_en, addr, wdata, output rdata);
endinterface
`default_nettype wire

// file: src/pbi_ram.sv
/*
 * Word array with per byte lane write enables and registered read data.
 * Assumes one access per core clock from the carrier.
 */
`timescale 1ns/1ps
`default_nettype none
module pbi_ram #(
    parameter int ADDR_W = 10
) (
    input wire logic core_clk_i,
    input wire logic clk_en_i,
    pbi_mem_if.mem bus
);
    logic [15:0] mem_q [0:(1<<ADDR_W)-1];

    // ----------------------------------------
    // Array write and read
    // ----------------------------------------
    // [RULE20] Masked lanes kept.
    // [RULE25] Lane bit split.
    always_ff @(posedge core_clk_i) begin
        if (clk_en_i && bus.wr_en) begin
            if (bus.byte_en[0]) begin
                mem_q[bus.addr][7:0] <= bus.wdata[7:0];
            end
            if (bus.byte_en[1]) begin
                mem_q[bus.addr][15:8] <= bus.wdata[15:8];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (clk_en_i) begin
            bus.rdata <= mem_q[bus.addr];
        end
    end
endmodule
`default_nettype wire

// file: src/pbi_wait_gen.sv
/*
 * Wait pin driver: timing shift and polarity of the wait signal.
 * Assumes the controller reports wait cycles and the row end warning.
 */
`timescale 1ns/1ps
`default_nettype none
module pbi_wait_gen (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic selected_i,
    input wire logic wait_cycle_i,
    input wire logic early_end_i,
    input wire logic early_start_i,
    input wire logic wait_cfg_i,
    input wire logic wait_pol_i,
    output logic wait_o,
    output logic wait_oe_o
);
    logic active;

    // ----------------------------------------
    // Wait level
    // ----------------------------------------
    // [RULE16] Early edge shift.
    always_comb begin
        if (wait_cfg_i) begin
            active = wait_cycle_i;
        end else begin
            active = (wait_cycle_i && !early_end_i) || early_start_i;
        end
    end

    // [RULE24] Configured polarity.
    // [RULE18] Driven while selected.
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            wait_o <= 1'b0;
            wait_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            wait_o <= wait_pol_i ? active : !active;
            wait_oe_o <= selected_i;
        end
    end
endmodule
`default_nettype wire

// file: src/pbi_core.sv
/*
 * Page and burst bus interface of a pseudo static memory: asynchronous and
 * page reads, asynchronous writes, synchronous bursts with wait handshake.
 * Assumes all pins, the burst clock among them, are synchronous to core_clk_i,
 * and that configuration words and refresh requests come from outside.
 */
`timescale 1ns/1ps
`default_nettype none
module pbi_core #(
    parameter int ADDR_W = 10,
    parameter int ROW_WORDS = 128,
    parameter int ACC_CYCLES = pbi_pkg::ACC_CYC,
    parameter int PAGE_CYCLES = pbi_pkg::PAGE_CYC,
    parameter int SEL_CYCLES = pbi_pkg::SEL_CYC,
    parameter int REF_CYCLES = pbi_pkg::REF_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic select_n_i,
    input wire logic address_valid_n_i,
    input wire logic write_en_n_i,
    input wire logic out_en_n_i,
    input wire logic low_byte_enable_n_i,
    input wire logic high_byte_enable_n_i,
    input wire logic burst_clk_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [15:0] dq_i,
    input wire logic [15:0] bus_config_reg_i,
    input wire logic [15:0] refresh_config_reg_i,
    input wire logic refresh_req_i,
    output logic [15:0] dq_o,
    output logic dq_oe_o,
    output logic wait_o,
    output logic wait_oe_o,
    output logic refresh_busy_o,
    output logic select_overtime_o
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [5:0] burst_words(input logic [2:0] code);
        case (code)
            pbi_pkg::LEN_4: burst_words = 6'h04;
            pbi_pkg::LEN_8: burst_words = 6'h08;
            pbi_pkg::LEN_16: burst_words = 6'h10;
            pbi_pkg::LEN_32: burst_words = 6'h20;
            default: burst_words = 6'h00;
        endcase
    endfunction

    function automatic logic row_last(input logic [ADDR_W-1:0] a);
        row_last = (a % ROW_WORDS) == (ROW_WORDS - 1);
    endfunction

    pbi_mem_if #(.ADDR_W(ADDR_W)) mif ();

    pbi_pkg::pbi_state_e state_q;
    logic bclk_q;
    logic bclk_rise;
    logic async_mode;
    logic fixed_lat;
    logic page_en;
    logic no_wrap;
    logic [5:0] len;
    logic [2:0] lat_code;
    logic wr_q;
    logic [ADDR_W-1:0] baddr_q;
    logic [5:0] words_q;
    logic [7:0] lat_q;
    logic [7:0] ref_q;
    logic [7:0] acc_q;
    logic [ADDR_W-1:0] last_addr_q;
    logic rd_valid_q;
    logic async_rd;
    logic async_wr;
    logic wr_hold_q;
    logic [1:0] be_q;
    logic [15:0] wdata_q;
    logic [ADDR_W-1:0] waddr_q;
    logic wr_strobe;
    logic burst_wr;
    logic lanes_off;
    logic [$clog2(SEL_CYCLES+1)-1:0] sel_cnt_q;
    logic [ADDR_W-1:0] next_addr;

    // ----------------------------------------
    // Configuration decode
    // ----------------------------------------
    // [RULE23] Mode select bit.
    assign async_mode = bus_config_reg_i[pbi_pkg::BC_ASYNC_BIT];
    assign fixed_lat = bus_config_reg_i[pbi_pkg::BC_FIXED_LAT_BIT];
    // [RULE4] Page enable bit.
    assign page_en = refresh_config_reg_i[pbi_pkg::RC_PAGE_BIT];
    assign no_wrap = bus_config_reg_i[pbi_pkg::BC_NO_WRAP_BIT];
    assign len = burst_words(bus_config_reg_i[pbi_pkg::BC_LEN_HI:pbi_pkg::BC_LEN_LO]);
    assign lat_code = bus_config_reg_i[pbi_pkg::BC_LAT_HI:pbi_pkg::BC_LAT_LO];
    assign bclk_rise = burst_clk_i && !bclk_q;
    // [RULE22] Both lanes off floats.
    assign lanes_off = low_byte_enable_n_i && high_byte_enable_n_i;
    // [RULE19] Clock low means asynchronous.
    assign async_rd = !select_n_i && !out_en_n_i && write_en_n_i && !burst_clk_i
                      && !address_valid_n_i && state_q == pbi_pkg::PBI_IDLE;
    assign async_wr = !select_n_i && !write_en_n_i && !lanes_off && !burst_clk_i
                      && state_q == pbi_pkg::PBI_IDLE;

    // ----------------------------------------
    // Burst address step
    // ----------------------------------------
    // [RULE8] Wrap within length or run on.
    always_comb begin
        next_addr = baddr_q + 1'b1;
        if (!no_wrap && len != 6'h00) begin
            next_addr = (baddr_q & ~ADDR_W'(len - 1'b1)) | (next_addr & ADDR_W'(len - 1'b1));
        end
    end

    // ----------------------------------------
    // Burst clock edge and refresh
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            bclk_q <= 1'b0;
        end else if (clk_en_i) begin
            bclk_q <= burst_clk_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ref_q <= 8'h00;
        end else if (clk_en_i) begin
            if (refresh_req_i && ref_q == 8'h00) begin
                ref_q <= 8'(REF_CYCLES);
            end else if (ref_q != 8'h00) begin
                ref_q <= ref_q - 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Burst sequencer
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state_q <= pbi_pkg::PBI_IDLE;
            wr_q <= 1'b0;
            baddr_q <= '0;
            words_q <= 6'h00;
            lat_q <= 8'h00;
        end else if (clk_en_i) begin
            if (select_n_i) begin
                state_q <= pbi_pkg::PBI_IDLE;
            end else if (bclk_rise) begin
                // [RULE15] Edges only advance.
                case (state_q)
                    pbi_pkg::PBI_IDLE: begin
                        // [RULE7] Address capture.
                        if (!address_valid_n_i && !async_mode) begin
                            baddr_q <= addr_i;
                            wr_q <= !write_en_n_i;
                            words_q <= 6'h00;
                            // [RULE9] Latency count.
                            // [RULE11] Refresh allowance.
                            lat_q <= 8'(lat_code) + ((fixed_lat || !write_en_n_i)
                                     ? 8'(pbi_pkg::REF_ALLOW_CLKS) : 8'h00);
                            state_q <= pbi_pkg::PBI_LAT;
                        end
                    end
                    pbi_pkg::PBI_LAT: begin
                        // [RULE10] Collision holds wait.
                        if (lat_q > 8'h01) begin
                            lat_q <= lat_q - 8'h01;
                        end else if (fixed_lat || wr_q || ref_q == 8'h00) begin
                            lat_q <= 8'h00;
                            state_q <= pbi_pkg::PBI_XFER;
                        end
                    end
                    pbi_pkg::PBI_XFER: begin
                        // [RULE14] One word per edge.
                        baddr_q <= next_addr;
                        words_q <= words_q + 6'h01;
                        if (len != 6'h00 && words_q + 6'h01 == len && (!no_wrap
                            || !row_last(baddr_q))) begin
                            state_q <= pbi_pkg::PBI_IDLE;
                        end else if ((no_wrap || len == 6'h00) && row_last(baddr_q)) begin
                            // [RULE13] Row end wait.
                            lat_q <= 8'(lat_code);
                            state_q <= pbi_pkg::PBI_ROW;
                        end
                    end
                    pbi_pkg::PBI_ROW: begin
                        if (lat_q > 8'h01) begin
                            lat_q <= lat_q - 8'h01;
                        end else begin
                            state_q <= pbi_pkg::PBI_XFER;
                        end
                    end
                    default: state_q <= pbi_pkg::PBI_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Asynchronous and page reads
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            acc_q <= 8'h00;
            last_addr_q <= '0;
            rd_valid_q <= 1'b0;
        end else if (clk_en_i) begin
            if (!async_rd) begin
                rd_valid_q <= 1'b0;
                acc_q <= 8'(ACC_CYCLES);
            end else if (addr_i != last_addr_q || !rd_valid_q && acc_q == 8'h00) begin
                last_addr_q <= addr_i;
                rd_valid_q <= 1'b0;
                // [RULE1] In-page fast access.
                // [RULE2] Upper bits restart access.
                if (page_en && rd_valid_q && addr_i[ADDR_W-1:pbi_pkg::PAGE_BITS]
                    == last_addr_q[ADDR_W-1:pbi_pkg::PAGE_BITS]) begin
                    acc_q <= 8'(PAGE_CYCLES);
                end else begin
                    acc_q <= 8'(ACC_CYCLES);
                end
            end else if (acc_q > 8'h01) begin
                acc_q <= acc_q - 8'h01;
            end else begin
                acc_q <= 8'h01;
                rd_valid_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Asynchronous write capture
    // ----------------------------------------
    // [RULE3] Full write each time.
    // [RULE21] Earliest rising edge.
    assign wr_strobe = wr_hold_q && !async_wr;
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            wr_hold_q <= 1'b0;
            be_q <= 2'b00;
            wdata_q <= 16'h0000;
            waddr_q <= '0;
        end else if (clk_en_i) begin
            wr_hold_q <= async_wr;
            if (async_wr) begin
                be_q <= {!high_byte_enable_n_i, !low_byte_enable_n_i};
                wdata_q <= dq_i;
                waddr_q <= addr_i;
            end
        end
    end

    // ----------------------------------------
    // Array access
    // ----------------------------------------
    assign burst_wr = state_q == pbi_pkg::PBI_XFER && wr_q && bclk_rise && !select_n_i;
    always_comb begin
        mif.wr_en = wr_strobe || burst_wr;
        mif.byte_en = wr_strobe ? be_q : {!high_byte_enable_n_i, !low_byte_enable_n_i};
        mif.wdata = wr_strobe ? wdata_q : dq_i;
        if (wr_strobe) begin
            mif.addr = waddr_q;
        end else if (state_q == pbi_pkg::PBI_IDLE) begin
            mif.addr = addr_i;
        end else begin
            mif.addr = baddr_q;
        end
    end

    pbi_ram #(.ADDR_W(ADDR_W)) u_ram (
        .core_clk_i(core_clk_i),
        .clk_en_i(clk_en_i),
        .bus(mif)
    );

    // ----------------------------------------
    // Data bus drive
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            dq_o <= 16'h0000;
            dq_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            dq_o <= mif.rdata;
            dq_oe_o <= !select_n_i && !out_en_n_i && !lanes_off && (rd_valid_q
                       || state_q == pbi_pkg::PBI_XFER && !wr_q);
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // [RULE26] Select time watch.
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            sel_cnt_q <= '0;
            select_overtime_o <= 1'b0;
            refresh_busy_o <= 1'b0;
        end else if (clk_en_i) begin
            refresh_busy_o <= ref_q != 8'h00;
            if (select_n_i) begin
                sel_cnt_q <= '0;
                select_overtime_o <= 1'b0;
            end else if (sel_cnt_q < SEL_CYCLES) begin
                sel_cnt_q <= sel_cnt_q + 1'b1;
            end else begin
                select_overtime_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Wait pin
    // ----------------------------------------
    pbi_wait_gen u_wait (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .selected_i(!select_n_i),
        .wait_cycle_i(state_q == pbi_pkg::PBI_LAT || state_q == pbi_pkg::PBI_ROW),
        .early_end_i(lat_q == 8'h01 && (fixed_lat || wr_q || ref_q == 8'h00)),
        .early_start_i(state_q == pbi_pkg::PBI_XFER && (no_wrap || len == 6'h00)
                       && row_last(baddr_q)),
        .wait_cfg_i(bus_config_reg_i[pbi_pkg::BC_WAIT_CFG_BIT]),
        .wait_pol_i(bus_config_reg_i[pbi_pkg::BC_WAIT_POL_BIT]),
        .wait_o(wait_o),
        .wait_oe_o(wait_oe_o)
    );
endmodule
`default_nettype wire

// file: verif/pbi_core_assertions.sv
/* Pin checker of pbi_core.
   Assumes clk_en_i stays high and a bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module pbi_core_chk #(
    parameter int SEL_CYCLES = 20
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic select_n_i,
    input wire logic address_valid_n_i,
    input wire logic write_en_n_i,
    input wire logic out_en_n_i,
    input wire logic low_byte_enable_n_i,
    input wire logic high_byte_enable_n_i,
    input wire logic burst_clk_i,
    input wire logic [15:0] bus_config_reg_i,
    input wire logic refresh_req_i,
    input wire logic dq_oe_o,
    input wire logic wait_o,
    input wire logic wait_oe_o,
    input wire logic refresh_busy_o,
    input wire logic select_overtime_o
);
    logic [15:0] low_q;
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i || select_n_i) begin
            low_q <= 16'h0000;
        end else if (low_q != 16'hFFFF) begin
            low_q <= low_q + 16'h0001;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_burst_go;
        !select_n_i && !address_valid_n_i && !bus_config_reg_i[15] && $rose(burst_clk_i);
    endsequence
    wait_driven_a: assert property ((!select_n_i)[*2] |-> wait_oe_o)
        else $error("wait not driven while selected");
    idle_quiet_a: assert property (select_n_i[*2] |-> !wait_oe_o && !dq_oe_o)
        else $error("pins driven while deselected");
    lanes_off_a: assert property ((low_byte_enable_n_i && high_byte_enable_n_i)[*2]
        |-> !dq_oe_o)
        else $error("data driven with both lanes off");
    write_quiet_a: assert property ((!write_en_n_i)[*2] |-> !dq_oe_o)
        else $error("data driven during write");
    oe_off_a: assert property (out_en_n_i[*2] |-> !dq_oe_o)
        else $error("data driven with output enable high");
    full_access_a: assert property ($fell(select_n_i) |-> (!dq_oe_o)[*6])
        else $error("first access shorter than full access");
    burst_wait_a: assert property (s_burst_go |-> ##[1:4] (wait_o == bus_config_reg_i[10]))
        else $error("wait not active at burst start");
    overtime_on_a: assert property (low_q > SEL_CYCLES + 2 |-> select_overtime_o)
        else $error("select overtime missed");
    overtime_off_a: assert property (low_q inside {[1:SEL_CYCLES - 2]}
        |-> !select_overtime_o)
        else $error("select overtime too early");
    refresh_go_a: assert property (refresh_req_i && !refresh_busy_o |-> ##[1:2] refresh_busy_o)
        else $error("refresh did not start");
endmodule
bind pbi_core pbi_core_chk #(.SEL_CYCLES(SEL_CYCLES)) u_chk (.core_clk_i, .rst_b_i,
    .select_n_i, .address_valid_n_i, .write_en_n_i, .out_en_n_i, .low_byte_enable_n_i,
    .high_byte_enable_n_i, .burst_clk_i, .bus_config_reg_i, .refresh_req_i, .dq_oe_o,
    .wait_o, .wait_oe_o, .refresh_busy_o, .select_overtime_o);
`default_nettype wire

// file: verif/pbi_host_model.sv
/* Memory controller model driving the pins of pbi_core.
   Assumes its tasks are called by the bench one at a time. */
`timescale 1ns/1ps
`default_nettype none
module pbi_host_model #(
    parameter int HOLD = 14
) (
    input wire logic core_clk_i,
    input wire logic [15:0] dq_i,
    input wire logic dq_oe_i,
    input wire logic wait_i,
    output logic select_n_o,
    output logic address_valid_n_o,
    output logic write_en_n_o,
    output logic out_en_n_o,
    output logic high_byte_enable_n_o,
    output logic low_byte_enable_n_o,
    output logic burst_clk_o,
    output logic [9:0] addr_o,
    output logic [15:0] dq_o
);
    logic drv = 1'b0;
    logic [15:0] wd = 16'h0000;
    initial begin
        {select_n_o, address_valid_n_o, write_en_n_o, out_en_n_o} = 4'hF;
        {high_byte_enable_n_o, low_byte_enable_n_o, burst_clk_o} = 3'h6;
        addr_o = 10'h000;
        dq_o = 16'h0000;
    end
    always @(negedge core_clk_i) begin
        dq_o <= drv ? wd : ~dq_o;
    end
    task automatic ctl(input logic [5:0] v);
        {select_n_o, address_valid_n_o, write_en_n_o, out_en_n_o, high_byte_enable_n_o,
            low_byte_enable_n_o} = v;
    endtask
    task automatic write(input logic [9:0] a, input logic [15:0] d, input logic [1:0] ln);
        @(negedge core_clk_i);
        addr_o = a;
        wd = d;
        drv = 1'b1;
        ctl({4'h1, ln});
        repeat (HOLD) @(negedge core_clk_i);
        ctl(6'h3F);
        @(negedge core_clk_i);
        drv = 1'b0;
        repeat (2) @(negedge core_clk_i);
    endtask
    task automatic look(input logic [9:0] a, input logic [15:0] e, output int n);
        @(negedge core_clk_i);
        addr_o = a;
        ctl(6'h08);
        n = 0;
        while (!(dq_oe_i === 1'b1 && dq_i === e) && n < 40) begin
            @(negedge core_clk_i);
            n++;
        end
    endtask
    task automatic done;
        @(negedge core_clk_i);
        ctl(6'h3F);
        repeat (2) @(negedge core_clk_i);
    endtask
    task automatic burst(input logic [9:0] a, input int r, input logic pol, output int w,
        output int nw);
        logic go;
        go = 1'b1;
        w = 0;
        nw = 0;
        @(negedge core_clk_i);
        addr_o = a;
        ctl(6'h08);
        for (int i = 0; i < r; i++) begin
            for (int k = 0; k < 4; k++) begin
                @(negedge core_clk_i);
                if (dq_oe_i === 1'b1 && dq_i === 16'hA000 + 16'(a) + 16'(nw)) nw++;
                if (k == 0) begin
                    if (i > 0 && wait_i !== pol) go = 1'b0;
                    if (go && i > 0) w++;
                    burst_clk_o = 1'b1;
                    address_valid_n_o = 1'(i > 0);
                end
                if (k == 2) burst_clk_o = 1'b0;
            end
        end
        done();
    endtask
endmodule
`default_nettype wire

// file: verif/pbi_core_bench.sv
/* Self-checking bench of pbi_core.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module pbi_core_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ref_req = 1'b0;
    logic [15:0] bc = 16'h1108;
    logic [15:0] rc = 16'h0000;
    logic sel_n, av_n, we_n, oe_n, hi_n, lo_n, bclk, dq_oe, wt, wt_oe, rbusy, ovt;
    logic [9:0] addr;
    logic [15:0] dq_w, dq_r;
    int errors = 0;
    int n_checks = 0;
    initial begin
        forever #4 clk = ~clk;
    end
    pbi_host_model h (.core_clk_i(clk), .dq_i(dq_r), .dq_oe_i(dq_oe), .wait_i(wt),
        .select_n_o(sel_n), .address_valid_n_o(av_n), .write_en_n_o(we_n),
        .out_en_n_o(oe_n), .high_byte_enable_n_o(hi_n), .low_byte_enable_n_o(lo_n),
        .burst_clk_o(bclk), .addr_o(addr), .dq_o(dq_w));
    pbi_core #(.SEL_CYCLES(20)) u_dut (.core_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(1'b1),
        .select_n_i(sel_n), .address_valid_n_i(av_n), .write_en_n_i(we_n),
        .out_en_n_i(oe_n), .low_byte_enable_n_i(lo_n), .high_byte_enable_n_i(hi_n),
        .burst_clk_i(bclk), .addr_i(addr), .dq_i(dq_w), .bus_config_reg_i(bc),
        .refresh_config_reg_i(rc), .refresh_req_i(ref_req), .dq_o(dq_r), .dq_oe_o(dq_oe),
        .wait_o(wt), .wait_oe_o(wt_oe), .refresh_busy_o(rbusy), .select_overtime_o(ovt));
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("Error %0t %s", $time, msg);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic t_lanes;
        int n;
        h.write(10'h100, 16'hA5C3, 2'b00);
        h.write(10'h100, 16'h1234, 2'b01);
        h.write(10'h100, 16'h5678, 2'b10);
        h.write(10'h100, 16'hFFFF, 2'b11);
        h.look(10'h100, 16'h1278, n);
        h.done();
        chk(n < 40, "lane merge");
        $display("test lanes done");
    endtask
    task automatic t_page;
        int nf, np, nr;
        for (int p = 0; p < 2; p++) begin
            rc = p ? 16'h0080 : 16'h0000;
            h.look(10'h020, 16'hA020, nf);
            h.look(10'h023, 16'hA023, np);
            h.look(10'h033, 16'hA033, nr);
            chk(ovt === 1'b1, "select overtime");
            h.done();
            chk((np < nr) == (p == 1), "page speed");
            chk(nr >= pbi_pkg::ACC_CYC && nr < 40, "new page access");
        end
        $display("test page done");
    endtask
    task automatic t_burst;
        int w0, w1, wx, nw;
        for (int i = 0; i < 4; i++) begin
            bc = {13'h0221, 3'(i + 1)};
            h.burst(10'h000, (4 << i) + 6, 1'b0, w0, nw);
            chk(nw == (4 << i), "burst length");
        end
        bc = 16'h1509;
        h.burst(10'h004, 10, 1'b1, w1, nw);
        bc = 16'h1109;
        h.burst(10'h004, 10, 1'b0, w0, nw);
        chk(w1 == w0 && w0 > 0 && nw == 4, "wait polarity");
        bc = 16'h5109;
        h.burst(10'h004, 14, 1'b0, wx, nw);
        chk(wx == w0 + pbi_pkg::REF_ALLOW_CLKS, "fixed latency");
        bc = 16'h1009;
        h.burst(10'h004, 10, 1'b0, wx, nw);
        chk(wx == w0 - 1, "wait timing");
        bc = 16'h1109;
        fork
            h.burst(10'h004, 14, 1'b0, wx, nw);
            begin
                repeat (8) @(negedge clk);
                ref_req = 1'b1;
                @(negedge clk);
                ref_req = 1'b0;
            end
        join
        chk(wx > w0 && nw == 4, "refresh collision");
        $display("test burst done");
    endtask
    initial begin
        #160000;
        errors++;
        $display("Error %0t timeout", $time);
        results();
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        for (int i = 0; i < 64; i++) h.write(10'(i), 16'hA000 + 16'(i), 2'b00);
        t_lanes();
        t_page();
        t_burst();
        results();
    end
endmodule
`default_nettype wire
